// ===== pixel_serializer_defs.vh
// Constants for the 21-to-3 pixel serializer
`ifndef PIXEL_SERIALIZER_DEFS_VH
`define PIXEL_SERIALIZER_DEFS_VH
`define PIX_WIDTH 21
`define LANE_COUNT 3
`define BITS_PER_LANE 7
`define SYS_CLK_MHZ 250
`define LOCK_TIME_MS 10
// Longest lock time in cycles, an exact product
`define LOCK_CYCLES (`LOCK_TIME_MS * 1000 * `SYS_CLK_MHZ)
// Divisor turning the lock time into a count of captures
`define LOCK_DIV 64
`define CLK_HIGH_SLOTS 4
`define SLOT_LAST 3'h6
`endif

// ===== lvds_pixel_serializer_21to3.v
// Pixel serializer: 21 parallel bits onto three lanes plus forwarded clock
`timescale 1ns/100ps
`include "pixel_serializer_defs.vh"

module lvds_pixel_serializer_21to3 #(
    parameter LOCK_CYCLES = `LOCK_CYCLES,
    parameter PIX_WIDTH = `PIX_WIDTH,
    parameter LANES = `LANE_COUNT
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Parallel side from graphics controller
    input wire [PIX_WIDTH-1:0] parallel_pixel_in,
    input wire pixel_shift_clock_in,
    input wire strobe_edge_select,
    input wire power_down_n,
    // Serial lanes, differential, with enables
    output reg [LANES-1:0] serial_lane_out_p,
    output reg [LANES-1:0] serial_lane_out_n,
    output reg [LANES-1:0] serial_lane_oe,
    // Forwarded clock pair
    output reg forwarded_clock_out_p,
    output reg forwarded_clock_out_n,
    output reg forwarded_clock_oe,
    // Status and back-pressure
    output reg lock_done,
    output reg word_dropped
);

localparam CW = 32;
// Sized once here so the compare below needs no part-select of a parameter
localparam [CW-1:0] LOCK_LIMIT = LOCK_CYCLES / `LOCK_DIV;

// ------------------------------------------------------------
// Input synchronisers
// ------------------------------------------------------------
reg [2:0] clk_sync_r;
reg [1:0] sel_sync_r;
reg [1:0] pd_sync_r;
reg [PIX_WIDTH-1:0] pix_s1_r;
reg [PIX_WIDTH-1:0] pix_s2_r;
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        clk_sync_r <= 3'h0;
        sel_sync_r <= 2'h0;
        pd_sync_r <= 2'h0;
        pix_s1_r <= {PIX_WIDTH{1'b0}};
        pix_s2_r <= {PIX_WIDTH{1'b0}};
    end
    else
    begin
        clk_sync_r <= {clk_sync_r[1:0], pixel_shift_clock_in};
        sel_sync_r <= {sel_sync_r[0], strobe_edge_select};
        pd_sync_r <= {pd_sync_r[0], power_down_n};
        pix_s1_r <= parallel_pixel_in;
        pix_s2_r <= pix_s1_r;
    end
end

// Edges seen on synchronised copies only
wire clk_rise = clk_sync_r[1] & ~clk_sync_r[2];
wire clk_fall = ~clk_sync_r[1] & clk_sync_r[2];
// Open pin reads low via pull-down, giving falling edge
wire rise_mode = sel_sync_r[1];
wire capture = rise_mode ? clk_rise : clk_fall;
wire powered = pd_sync_r[1];

// ------------------------------------------------------------
// Lock timer: output only valid once settled
// ------------------------------------------------------------
reg [CW-1:0] lock_cnt_r;
reg locked_r;
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        lock_cnt_r <= {CW{1'b0}};
        locked_r <= 1'b0;
    end
    else if (!powered)
    begin
        lock_cnt_r <= {CW{1'b0}};
        locked_r <= 1'b0;
    end
    else if (!locked_r && capture)
    begin
        // Counts only while the shift clock toggles
        if (lock_cnt_r >= LOCK_LIMIT)
            locked_r <= 1'b1;
        lock_cnt_r <= lock_cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
end

// ------------------------------------------------------------
// Two-entry buffer between capture and serializer
// ------------------------------------------------------------
reg [PIX_WIDTH-1:0] buf_mem_r [0:1];
reg wr_ptr_r;
reg rd_ptr_r;
reg [1:0] count_r;
wire buf_in_ready = (count_r != 2'h2);
wire buf_out_valid = (count_r != 2'h0);
wire push = capture & locked_r;
wire do_push = push & buf_in_ready;
wire pop;
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
        count_r <= 2'h0;
        buf_mem_r[0] <= {PIX_WIDTH{1'b0}};
        buf_mem_r[1] <= {PIX_WIDTH{1'b0}};
    end
    else if (!powered)
    begin
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
        count_r <= 2'h0;
    end
    else
    begin
        if (do_push)
        begin
            buf_mem_r[wr_ptr_r] <= pix_s2_r;
            wr_ptr_r <= ~wr_ptr_r;
        end
        if (pop)
            rd_ptr_r <= ~rd_ptr_r;
        case ({do_push, pop})
            2'b10: count_r <= count_r + 2'h1;
            2'b01: count_r <= count_r - 2'h1;
            default: count_r <= count_r;
        endcase
    end
end

// ------------------------------------------------------------
// Serializer: seven slots per shift clock period
// ------------------------------------------------------------
// Slot pacing from the measured shift clock period
reg [7:0] period_cnt_r;
reg [7:0] period_r;
reg [7:0] slot_tick_r;
reg [2:0] slot_r;
reg active_r;
reg [PIX_WIDTH-1:0] shift_word_r;
wire slot_step = (slot_tick_r == 8'h00);
wire [7:0] slot_len = (period_r / 8'h07 == 8'h00) ? 8'h01 : period_r / 8'h07;
assign pop = buf_out_valid & (!active_r | (slot_step & (slot_r == `SLOT_LAST)));

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        period_cnt_r <= 8'h00;
        period_r <= 8'h10;
    end
    else if (capture)
    begin
        period_cnt_r <= 8'h00;
        period_r <= period_cnt_r + 8'h01;
    end
    else if (period_cnt_r != 8'hFF)
        period_cnt_r <= period_cnt_r + 8'h01;
end

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        slot_tick_r <= 8'h00;
        slot_r <= 3'h0;
        active_r <= 1'b0;
        shift_word_r <= {PIX_WIDTH{1'b0}};
    end
    else if (!powered)
    begin
        active_r <= 1'b0;
        slot_r <= 3'h0;
        slot_tick_r <= 8'h00;
    end
    else if (pop)
    begin
        shift_word_r <= buf_mem_r[rd_ptr_r];
        active_r <= 1'b1;
        slot_r <= 3'h0;
        slot_tick_r <= slot_len - 8'h01;
    end
    else if (active_r)
    begin
        if (slot_step)
        begin
            slot_tick_r <= slot_len - 8'h01;
            if (slot_r == `SLOT_LAST)
                active_r <= 1'b0; // Underrun: idle until next word
            else
                slot_r <= slot_r + 3'h1;
        end
        else
            slot_tick_r <= slot_tick_r - 8'h01;
    end
end

// ------------------------------------------------------------
// Lane mapping: lane k, slot s carries bit 7k+6-s, MSB slot first
// ------------------------------------------------------------
wire [LANES-1:0] lane_bit;
genvar k;
generate
    for (k = 0; k < LANES; k = k + 1)
    begin : g_lane
        assign lane_bit[k] = shift_word_r[k*`BITS_PER_LANE + (`SLOT_LAST - slot_r)];
    end
endgenerate

// Forwarded clock high for first four slots, low for three
wire fwd_clk = active_r & (slot_r < `CLK_HIGH_SLOTS);

// ------------------------------------------------------------
// Output registers; floated while powered down
// ------------------------------------------------------------
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        serial_lane_out_p <= {LANES{1'b0}};
        serial_lane_out_n <= {LANES{1'b0}};
        serial_lane_oe <= {LANES{1'b0}};
        forwarded_clock_out_p <= 1'b0;
        forwarded_clock_out_n <= 1'b0;
        forwarded_clock_oe <= 1'b0;
        lock_done <= 1'b0;
        word_dropped <= 1'b0;
    end
    else
    begin
        serial_lane_out_p <= lane_bit & {LANES{active_r}};
        serial_lane_out_n <= ~lane_bit | {LANES{~active_r}};
        serial_lane_oe <= {LANES{powered & locked_r}};
        forwarded_clock_out_p <= fwd_clk;
        forwarded_clock_out_n <= ~fwd_clk;
        forwarded_clock_oe <= powered & locked_r;
        lock_done <= locked_r;
        // Pulse: a capture found the buffer full
        word_dropped <= push & ~buf_in_ready;
    end
end

endmodule

// ===== pixel_ser_chk_assertions.sv
// Port checker for the pixel serializer
`timescale 1ns/100ps
module pixel_ser_chk (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Control
    input wire power_down_n,
    // Outputs watched
    input wire [2:0] serial_lane_out_p,
    input wire [2:0] serial_lane_out_n,
    input wire [2:0] serial_lane_oe,
    input wire forwarded_clock_out_p,
    input wire forwarded_clock_out_n,
    input wire forwarded_clock_oe,
    input wire lock_done
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Power down held well past the input synchroniser
    sequence pd_held;
        !power_down_n [*8];
    endsequence
    sequence clk_up;
        $rose(forwarded_clock_out_p);
    endsequence
    // Pairs stay complementary while driven, idle included
    property lane_diff;
        serial_lane_oe[0] |-> (serial_lane_out_p ^ serial_lane_out_n) == 3'h7;
    endproperty
    property clk_diff;
        forwarded_clock_oe |-> forwarded_clock_out_p != forwarded_clock_out_n;
    endproperty
    // Power down cuts a word short, so phase widths are only checked while powered
    property clk_high;
        disable iff (!resetn || !power_down_n)
            clk_up |-> forwarded_clock_out_p [*4];
    endproperty
    property clk_low;
        disable iff (!resetn || !power_down_n)
            $fell(forwarded_clock_out_p) |-> !forwarded_clock_out_p [*3];
    endproperty
    AST_LANE_DIFF: assert property (lane_diff)
        else $error("lane pair not complementary");
    AST_CLK_DIFF: assert property (clk_diff)
        else $error("clock pair not complementary");
    AST_OE_SAME: assert property (serial_lane_oe == {3{forwarded_clock_oe}})
        else $error("lane and clock enables differ");
    AST_OE_LOCK: assert property (forwarded_clock_oe |-> lock_done)
        else $error("driving before lock");
    AST_PD_FLOAT: assert property (pd_held |-> serial_lane_oe == 3'h0 && !forwarded_clock_oe)
        else $error("outputs driven in power down");
    AST_PD_UNLOCK: assert property (pd_held |-> !lock_done)
        else $error("lock kept in power down");
    // Slots last at least one cycle, so a high phase spans four cycles at least
    AST_CLK_HIGH: assert property (clk_high)
        else $error("clock high phase too short");
    AST_CLK_LOW: assert property (clk_low)
        else $error("clock low phase too short");
endmodule
bind lvds_pixel_serializer_21to3 pixel_ser_chk chk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .power_down_n(power_down_n),
    .serial_lane_out_p(serial_lane_out_p),
    .serial_lane_out_n(serial_lane_out_n),
    .serial_lane_oe(serial_lane_oe),
    .forwarded_clock_out_p(forwarded_clock_out_p),
    .forwarded_clock_out_n(forwarded_clock_out_n),
    .forwarded_clock_oe(forwarded_clock_oe),
    .lock_done(lock_done)
);

// ===== pixel_source.sv
// Graphics controller model: shift clock and pixel word
`timescale 1ns/100ps
module pixel_source (
    // Control from bench
    input wire run,
    input wire rise_cap,
    input wire [20:0] word,
    // Parallel side
    output logic pclk,
    output logic [20:0] data
);
    initial
    begin
        pclk = 1'b0;
        data = 21'h0;
    end
    // Word valid only around the capture edge, so a wrong edge sees it inverted
    always
    begin
        if (run)
        begin
            pclk = ~rise_cap;
            #8 data = word;
            #24 pclk = rise_cap;
            #8 data = ~word;
            #24;
        end
        else
            #4;
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the pixel serializer
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 0, resetn = 0, sel = 0, pd_n = 1, run = 0;
    logic [20:0] word = 21'h0, data;
    logic pclk;
    wire [2:0] lp, ln, loe;
    wire cp, cn, coe, lock, drop;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    always #2 sys_clk = ~sys_clk;
    pixel_source src (.run(run), .rise_cap(sel), .word(word), .pclk(pclk), .data(data));
    // Short lock count keeps the run brief: eleven captures
    lvds_pixel_serializer_21to3 #(.LOCK_CYCLES(640)) DUT (.sys_clk(sys_clk), .resetn(resetn),
        .parallel_pixel_in(data), .pixel_shift_clock_in(pclk), .strobe_edge_select(sel),
        .power_down_n(pd_n), .serial_lane_out_p(lp), .serial_lane_out_n(ln),
        .serial_lane_oe(loe), .forwarded_clock_out_p(cp), .forwarded_clock_out_n(cn),
        .forwarded_clock_oe(coe), .lock_done(lock), .word_dropped(drop));
    task tally_and_finish;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Drop pulses last one cycle, so count them rather than sample once
    logic [20:0] drop_cnt = 21'h0;
    always @(posedge sys_clk)
        if (drop === 1'b1)
            drop_cnt <= drop_cnt + 21'h1;
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish;
        end
    end
    task chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wait_cp(input logic lvl);
        int n;
        n = 0;
        while (cp !== lvl && n < 300)
        begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    // Slot lasts two cycles at a 64 ns shift clock; MSB slot first
    task get_word(output logic [20:0] w);
        wait_cp(0);
        wait_cp(1);
        for (int s = 0; s < 7; s++)
        begin
            for (int k = 0; k < 3; k++)
                w[7*k+6-s] = lp[k];
            repeat (2) @(negedge sys_clk);
        end
    endtask
    task t_reset;
        repeat (5) @(negedge sys_clk);
        chk("reset outs", 21'h0, {7'h0, coe, lock, drop, loe, lp, ln, cp, cn});
        resetn = 1;
    endtask
    task t_lock(input logic [20:0] w);
        int n;
        word = w;
        run = 1;
        repeat (80) @(negedge sys_clk);
        chk("early lock", 21'h0, {20'h0, lock});
        n = 0;
        while (lock !== 1'b1 && n < 400)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("lock oe", 21'hF, {17'h0, coe, loe});
    endtask
    task t_frame(input logic s, input logic [20:0] w);
        logic [20:0] got, d0;
        run = 0;
        // Long enough for the last old word to leave the lanes
        repeat (40) @(negedge sys_clk);
        d0 = drop_cnt;
        sel = s;
        word = w;
        run = 1;
        get_word(got);
        get_word(got);
        chk("word", w, got);
        chk("no drop", d0, drop_cnt);
    endtask
    task t_pd;
        pd_n = 0;
        repeat (10) @(negedge sys_clk);
        chk("pd outs", 21'h0, {16'h0, coe, lock, loe});
        pd_n = 1;
    endtask
    initial
    begin
        t_reset;
        t_lock(21'h1A5C3E);
        t_frame(0, 21'h1A5C3E);
        t_frame(1, 21'h0F0E1D);
        t_pd;
        t_lock(21'h15AA55);
        t_frame(0, 21'h00F0F1);
        tally_and_finish;
    end
endmodule
